// ===== boot_params.svh
`ifndef BOOT_PARAMS_SVH
`define BOOT_PARAMS_SVH

// Timing of the strobe sample after reset: base plus two per wait state
`define STRAP_BASE_CYCLES     36
`define STRAP_PER_WAIT        2
// Delay read location in global space
`define DELAY_READ_ADDR       16'h8000
// Load placement
`define LOAD_START_ADDR       16'h0200
`define EXT_START_ADDR        16'h0800
`define BRANCH_ADDR           16'h0FA00
// Internal RAM words filled before external memory: blocks zero, one, three
`define INT_RAM_WORDS         12'h600
// Status word fields
`define ST_LEN_HI_MSB         2
`define ST_DOWNLOAD_BIT       3
`define ST_WIDE_BIT           4
// Interrupt word fields
`define IW_MASK_MSB           5
`define IW_CFG_LSB            6
// Checksum verdict on port zero
`define VERDICT_PASS          16'h00FF
`define VERDICT_FAIL          16'h0000
// Program block configurations
`define CFG_BLK0              2'h0
`define CFG_BLK01             2'h1
`define CFG_BLK013            2'h2

`endif

// ===== boot_pkg.sv
package boot_pkg;

	// Download sequence states
	typedef enum logic [3:0] {
		ST_DELAY   = 4'h0,
		ST_SAMPLE  = 4'h1,
		ST_STATUS  = 4'h2,
		ST_INTR    = 4'h3,
		ST_LENGTH  = 4'h4,
		ST_PROG    = 4'h5,
		ST_CSUM    = 4'h6,
		ST_SYNC    = 4'h7,
		ST_RUN     = 4'h8,
		ST_OTHER   = 4'h9
	} boot_state_e;

	// Receive handshake phases
	typedef enum logic [1:0] {
		HS_WAIT_LOW  = 2'h0,
		HS_WAIT_HIGH = 2'h1,
		HS_IDLE      = 2'h2
	} hs_state_e;

endpackage

// ===== parallel_boot_download.sv
// Summary of operation
// RULE_01: Low strobe at sample selects parallel download
// RULE_02: Sample strobe 36 plus 2d cycles
// RULE_03: Delay read of 08000h, result ignored
// RULE_04: Load from 0200h, then branch 0FA00h
// RULE_05: Words come through port zero, 8/16
// RULE_06: Host sets data then drops strobe
// RULE_07: Falling strobe latches word, stores it
// RULE_08: Flag high after word is stored
// RULE_09: Flag low once strobe returns high
// RULE_10: Host may ignore flag with spacing
// RULE_11: 8-bit sequence uses low byte only
// RULE_12: 8-bit program words low then high
// RULE_13: 16-bit program and checksum single transfer
// RULE_14: Status bit3 download, bit4 wide format
// RULE_15: Interrupt word bits 5..0 to mask
// RULE_16: Interrupt bits 7..6 pick program blocks
// RULE_17: Blocks zero, one, three stay data
// RULE_18: Eleven-bit length from status and length
// RULE_19: Overflow words go to external 0800h
// RULE_20: Checksum verdict on flag and port
// RULE_21: Sync strobe edge branches, data dropped
// RULE_22: Checksum is low 16 bits of sum
// RULE_23: Port shows 0FFh pass, 00h fail
// RULE_24: Apply config, branch regardless of verdict
// RULE_25: Download bit clear loads nothing
//
// The implementer's own choices: the address map and the address-and-strobe port.
`include "boot_params.svh"
`timescale 1ns/1ps
`default_nettype none

module parallel_boot_download #(
	parameter int WAIT_STATES = 0,
	parameter int LEN_BITS    = 11
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Host handshake
	input  wire logic        host_strobe_n,
	output logic             ack_flag_out,
	// Parallel port zero
	input  wire logic [15:0] parallel_port_zero,
	output logic [15:0]      port_out_data,
	output logic             port_out_valid,
	// Delay read of global memory
	output logic             delay_rd,
	output logic [15:0]      delay_rd_addr,
	// Data memory write
	output logic             mem_wr,
	output logic [15:0]      mem_addr,
	output logic [15:0]      mem_wdata,
	// Final configuration and branch
	output logic [5:0]       interrupt_mask,
	output logic             ram_block_zero,
	output logic             ram_block_one,
	output logic             ram_block_two,
	output logic             ram_block_three,
	output logic             branch,
	output logic [15:0]      branch_addr,
	output logic             other_mode
);

	localparam int SAMPLE_CYCLES =
		`STRAP_BASE_CYCLES + `STRAP_PER_WAIT * WAIT_STATES;

	// Refuse settings the logic cannot serve
	if (WAIT_STATES < 0 || SAMPLE_CYCLES > 255) begin : g_bad_wait
		$error("WAIT_STATES out of range");
	end
	if (LEN_BITS != 11) begin : g_bad_len
		$error("LEN_BITS must be 11");
	end

	// Operating notes for users of this block
	// The strobe level is taken once, after the reset delay count.
	// A host that floats the strobe through reset may pick the wrong
	// mode, so it should drive a firm level from power-up.
	// The delay read is issued but its data is never used here; the
	// external memory path that would use it lives outside this block.
	// Each word is taken on the first cycle the strobe is seen low
	// while the handshake waits; edges while the flag is high are
	// ignored, so a host that skips the flag must leave enough time.
	// After a failed checksum the flag stays low, so a host that
	// polls the flag must time out and read the verdict instead.
	// Program words past the stated length are neither stored nor
	// summed; the sequence moves to the checksum at the length.
	// Internal blocks take the first words in ascending order; the
	// rest goes to external data memory from its base upward.
	// The final memory map and mask are applied while the sync
	// transfer is awaited, so they are in place before the branch.
	// With the download bit clear nothing is loaded and the branch
	// follows the status word directly.
	// The flag always drops once the strobe returns high, also for
	// the status-only boot, so the host never sees it stuck high.

	boot_pkg::boot_state_e state_q;
	boot_pkg::hs_state_e   hs_q;
	logic [7:0]            dly_q;
	// Strobe sampling and word capture
	logic                  strobe_q;
	logic                  fall;
	logic                  got_word;
	logic [15:0]           word;
	// Format, length and checksum state
	logic                  wide_q;
	logic                  half_q;
	logic [7:0]            low_byte_q;
	logic [2:0]            len_hi_q;
	logic [10:0]           len_q;
	logic [11:0]           cnt_q;
	logic [15:0]           sum_q;
	logic [7:0]            intr_q;
	logic                  pass_q;
	logic                  prog_done;
	logic [15:0]           prog_word;

	// Falling edge of the host strobe acts as the data latch
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe_q <= 1'b1;
		end else begin
			strobe_q <= host_strobe_n;
		end
	end
	assign fall = strobe_q && !host_strobe_n; // RULE_07

	// A word is taken only when the handshake waits for one
	assign got_word = fall && hs_q == boot_pkg::HS_WAIT_LOW; // RULE_06
	assign word = parallel_port_zero; // RULE_05

	// Assembled program word for either format
	assign prog_word = wide_q ? word // RULE_13
		: {word[7:0], low_byte_q}; // RULE_12
	assign prog_done = (cnt_q[10:0] == len_q) || cnt_q[11];

	// Receive handshake: flag high after storing, low on strobe release
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hs_q         <= boot_pkg::HS_IDLE;
			ack_flag_out <= 1'b0;
		end else begin
			unique case (hs_q)
				boot_pkg::HS_IDLE: begin
					if (state_q == boot_pkg::ST_STATUS && host_strobe_n) begin
						hs_q         <= boot_pkg::HS_WAIT_LOW;
						ack_flag_out <= 1'b0;
					end
				end
				boot_pkg::HS_WAIT_LOW: begin
					if (got_word) begin
						hs_q <= boot_pkg::HS_WAIT_HIGH;
						if (state_q == boot_pkg::ST_CSUM && (!wide_q && half_q
							|| wide_q))
							ack_flag_out <= (prog_word == sum_q); // RULE_20
						else if (state_q == boot_pkg::ST_SYNC)
							ack_flag_out <= ack_flag_out;
						else
							ack_flag_out <= 1'b1; // RULE_08
					end
				end
				boot_pkg::HS_WAIT_HIGH: begin
					// Release always drops the flag, even after the last word
					if (host_strobe_n) begin
						ack_flag_out <= 1'b0; // RULE_09
						if (state_q == boot_pkg::ST_RUN)
							hs_q <= boot_pkg::HS_IDLE;
						else
							hs_q <= boot_pkg::HS_WAIT_LOW;
					end
				end
				default: hs_q <= boot_pkg::HS_IDLE;
			endcase
		end
	end

	// Reset delay count, the strobe sample and the word sequence
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= boot_pkg::ST_DELAY;
			dly_q    <= 8'h00;
			wide_q   <= 1'b0;
			half_q   <= 1'b0;
			len_hi_q <= 3'h0;
			len_q    <= 11'h000;
			cnt_q    <= 12'h000;
			intr_q   <= 8'h00;
		end else begin
			unique case (state_q)
				boot_pkg::ST_DELAY: begin
					dly_q <= dly_q + 8'h01;
					if (dly_q == 8'(SAMPLE_CYCLES - 1)) // RULE_02
						state_q <= boot_pkg::ST_SAMPLE;
				end
				boot_pkg::ST_SAMPLE: begin
					if (!host_strobe_n) // RULE_01
						state_q <= boot_pkg::ST_STATUS;
					else
						state_q <= boot_pkg::ST_OTHER;
				end
				boot_pkg::ST_STATUS: begin
					if (got_word) begin
						wide_q   <= word[`ST_WIDE_BIT]; // RULE_14
						len_hi_q <= word[`ST_LEN_HI_MSB:0];
						if (word[`ST_DOWNLOAD_BIT])
							state_q <= boot_pkg::ST_INTR;
						else
							state_q <= boot_pkg::ST_RUN; // RULE_25
					end
				end
				boot_pkg::ST_INTR: begin
					if (got_word) begin
						intr_q  <= word[7:0]; // RULE_11
						state_q <= boot_pkg::ST_LENGTH;
					end
				end
				boot_pkg::ST_LENGTH: begin
					if (got_word) begin
						len_q   <= {len_hi_q, word[7:0]}; // RULE_18
						cnt_q   <= 12'h000;
						half_q  <= 1'b0;
						state_q <= ({len_hi_q, word[7:0]} == 11'h000)
							? boot_pkg::ST_CSUM : boot_pkg::ST_PROG;
					end
				end
				boot_pkg::ST_PROG: begin
					if (got_word) begin
						if (wide_q || half_q) begin
							half_q <= 1'b0;
							cnt_q  <= cnt_q + 12'h001;
							if (cnt_q[10:0] + 11'h001 == len_q)
								state_q <= boot_pkg::ST_CSUM; // RULE_04
						end else begin
							half_q <= 1'b1;
						end
					end
				end
				boot_pkg::ST_CSUM: begin
					if (got_word) begin
						if (wide_q || half_q) begin
							half_q  <= 1'b0;
							state_q <= boot_pkg::ST_SYNC;
						end else begin
							half_q <= 1'b1;
						end
					end
				end
				boot_pkg::ST_SYNC: begin
					if (got_word) // RULE_21
						state_q <= boot_pkg::ST_RUN;
				end
				boot_pkg::ST_RUN: state_q <= boot_pkg::ST_RUN;
				boot_pkg::ST_OTHER: state_q <= boot_pkg::ST_OTHER;
				default: state_q <= boot_pkg::ST_OTHER;
			endcase
		end
	end

	// Low byte holder for 8-bit program and checksum words
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_byte_q <= 8'h00;
		end else if (got_word && !wide_q && !half_q) begin
			low_byte_q <= word[7:0];
		end
	end

	// Running checksum over program words only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sum_q <= 16'h0000;
		end else if (got_word && state_q == boot_pkg::ST_PROG
			&& (wide_q || half_q) && !prog_done) begin
			sum_q <= sum_q + prog_word; // RULE_22
		end
	end

	// Store program words: internal blocks first, then external memory
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_wr    <= 1'b0;
			mem_addr  <= 16'h0000;
			mem_wdata <= 16'h0000;
		end else begin
			mem_wr <= 1'b0;
			if (got_word && state_q == boot_pkg::ST_PROG
				&& (wide_q || half_q)) begin
				mem_wr    <= 1'b1;
				mem_wdata <= prog_word;
				if (cnt_q < `INT_RAM_WORDS) // RULE_17
					mem_addr <= `LOAD_START_ADDR + {4'h0, cnt_q};
				else // RULE_19
					mem_addr <= `EXT_START_ADDR
						+ {4'h0, cnt_q - `INT_RAM_WORDS};
			end
		end
	end

	// Checksum verdict presented on port zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pass_q         <= 1'b0;
			port_out_data  <= 16'h0000;
			port_out_valid <= 1'b0;
		end else if (got_word && state_q == boot_pkg::ST_CSUM
			&& (wide_q || half_q)) begin
			pass_q         <= (prog_word == sum_q);
			port_out_valid <= 1'b1;
			port_out_data  <= (prog_word == sum_q) // RULE_23
				? `VERDICT_PASS : `VERDICT_FAIL;
		end
	end

	// Delay read of global memory before the strobe sample
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			delay_rd      <= 1'b0;
			delay_rd_addr <= 16'h0000;
		end else begin
			delay_rd      <= (state_q == boot_pkg::ST_DELAY)
				&& (dly_q == 8'h00); // RULE_03
			delay_rd_addr <= `DELAY_READ_ADDR;
		end
	end

	// Memory and interrupt configuration applied after the checksum
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_mask  <= 6'h00;
			ram_block_zero  <= 1'b0;
			ram_block_one   <= 1'b0;
			ram_block_two   <= 1'b0;
			ram_block_three <= 1'b0;
		end else if (state_q == boot_pkg::ST_SYNC && !got_word) begin
			interrupt_mask  <= intr_q[`IW_MASK_MSB:0]; // RULE_15
			ram_block_zero  <= 1'b1; // RULE_24
			ram_block_one   <= intr_q[7:`IW_CFG_LSB] == `CFG_BLK01
				|| intr_q[7:`IW_CFG_LSB] == `CFG_BLK013; // RULE_16
			ram_block_two   <= 1'b0;
			ram_block_three <= intr_q[7:`IW_CFG_LSB] == `CFG_BLK013;
		end
	end

	// Branch to the loaded program, or hand over to the other modes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			branch      <= 1'b0;
			branch_addr <= 16'h0000;
			other_mode  <= 1'b0;
		end else begin
			branch     <= 1'b0;
			other_mode <= state_q == boot_pkg::ST_OTHER;
			if ((state_q == boot_pkg::ST_SYNC || state_q
				== boot_pkg::ST_STATUS) && got_word
				&& (state_q == boot_pkg::ST_SYNC
				|| !word[`ST_DOWNLOAD_BIT])) begin
				branch      <= 1'b1;
				branch_addr <= `BRANCH_ADDR; // RULE_04
			end
		end
	end

endmodule // parallel_boot_download

`default_nettype wire

// ===== boot_download_sva.sv
`timescale 1ns/1ps
`default_nettype none

module boot_download_sva (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// Handshake and verdict
	input wire logic        host_strobe_n,
	input wire logic        ack_flag_out,
	input wire logic [15:0] port_out_data,
	input wire logic        port_out_valid,
	// Delay read, fill and branch
	input wire logic        delay_rd,
	input wire logic [15:0] delay_rd_addr,
	input wire logic        mem_wr,
	input wire logic [15:0] mem_addr,
	input wire logic        branch,
	input wire logic [15:0] branch_addr,
	input wire logic        other_mode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic        seen_q;
	logic [15:0] last_q;
	// Last fill address, for the ascending order check
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_q <= 1'b0;
			last_q <= 16'h0000;
		end else if (mem_wr) begin
			seen_q <= 1'b1;
			last_q <= mem_addr;
		end
	end
	sequence s_release;
		ack_flag_out && host_strobe_n;
	endsequence
	sequence s_flag_low;
		##[1:2] !ack_flag_out;
	endsequence
	property p_delay_rd;
		delay_rd |-> delay_rd_addr == 16'h8000;
	endproperty
	a_delay_rd: assert property (p_delay_rd) else $error("delay addr");
	property p_branch;
		branch |-> branch_addr == 16'hFA00 ##1 !branch;
	endproperty
	a_branch: assert property (p_branch) else $error("branch");
	property p_fill_range;
		mem_wr |-> mem_addr >= 16'h0200 && mem_addr < 16'h0A00;
	endproperty
	a_fill_range: assert property (p_fill_range) else $error("range");
	property p_fill_order;
		mem_wr |-> mem_addr == (seen_q ? last_q + 16'h0001 : 16'h0200);
	endproperty
	a_fill_order: assert property (p_fill_order) else $error("order");
	property p_wr_ack;
		mem_wr |-> ##[0:1] ack_flag_out;
	endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("no ack");
	property p_ack_rise;
		$rose(ack_flag_out) |-> !host_strobe_n;
	endproperty
	a_ack_rise: assert property (p_ack_rise) else $error("ack rise");
	property p_ready;
		s_release |-> s_flag_low;
	endproperty
	a_ready: assert property (p_ready) else $error("ready");
	property p_verdict;
		port_out_valid |-> port_out_data inside {16'h00FF, 16'h0000};
	endproperty
	a_verdict: assert property (p_verdict) else $error("verdict");
	property p_verdict_flag;
		$rose(port_out_valid) |-> ##[0:1] ack_flag_out == port_out_data[0];
	endproperty
	a_verdict_flag: assert property (p_verdict_flag) else $error("flag");
	property p_other;
		other_mode |-> !mem_wr && !branch;
	endproperty
	a_other: assert property (p_other) else $error("other mode");
endmodule // boot_download_sva

bind parallel_boot_download boot_download_sva boot_download_sva_i (
	.ref_clk, .rst_n, .host_strobe_n, .ack_flag_out, .port_out_data,
	.port_out_valid, .delay_rd, .delay_rd_addr, .mem_wr, .mem_addr,
	.branch, .branch_addr, .other_mode
);

`default_nettype wire

// ===== boot_host.sv
`timescale 1ns/1ps
`default_nettype none

module boot_host (
	// Clock
	input wire logic         ref_clk,
	// Handshake
	output var logic         host_strobe_n,
	input wire logic         ack_flag_out,
	// Port zero
	output var logic [15:0]  parallel_port_zero
);
	// Strobe low and port zero cleared at time zero
	initial begin
		host_strobe_n = 1'b0;
		parallel_port_zero = 16'h0000;
	end
	// Level held on the strobe through reset picks the mode
	task automatic strap(input logic lvl);
		host_strobe_n <= lvl;
	endtask
	// One word: data, strobe low, ack or fixed spacing, release, ready
	task automatic send(input logic [15:0] w, input logic ack,
			output logic ok);
		int n;
		n = 0;
		parallel_port_zero <= w;
		@(posedge ref_clk);
		host_strobe_n <= 1'b0;
		@(posedge ref_clk);
		while ((ack ? !ack_flag_out : n < 4) && n < 40) begin
			@(posedge ref_clk);
			n++;
		end
		ok = n < 40;
		host_strobe_n <= 1'b1;
		parallel_port_zero <= ~w;
		@(posedge ref_clk);
		n = 0;
		while (ack_flag_out && n < 40) begin
			@(posedge ref_clk);
			n++;
		end
		ok = ok && n < 40;
	endtask
endmodule // boot_host

`default_nettype wire

// ===== parallel_boot_download_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "boot_params.svh"

module parallel_boot_download_bench;
	logic        ref_clk, rst_n, host_strobe_n, ack_flag_out;
	logic [15:0] parallel_port_zero, port_out_data, delay_rd_addr;
	logic [15:0] mem_addr, mem_wdata, branch_addr;
	logic        port_out_valid, delay_rd, mem_wr, branch, other_mode;
	logic [5:0]  interrupt_mask;
	logic        ram_block_zero, ram_block_one, ram_block_two;
	logic        ram_block_three;
	int          bad_count, checked, branches, delays;
	logic [15:0] wr_addr[$];
	logic [15:0] wr_data[$];
	logic [3:0]  blocks;
	assign blocks = {ram_block_three, ram_block_two, ram_block_one,
		ram_block_zero};
	parallel_boot_download parallel_boot_download_i (.ref_clk, .rst_n,
		.host_strobe_n, .ack_flag_out, .parallel_port_zero,
		.port_out_data, .port_out_valid, .delay_rd, .delay_rd_addr,
		.mem_wr, .mem_addr, .mem_wdata, .interrupt_mask, .ram_block_zero,
		.ram_block_one, .ram_block_two, .ram_block_three, .branch,
		.branch_addr, .other_mode);
	boot_host boot_host_i (.ref_clk, .host_strobe_n, .ack_flag_out,
		.parallel_port_zero);
	// 25 MHz clock
	initial ref_clk = 1'b0;
	always #20 ref_clk = ~ref_clk;
	// Log fills, branches and delay reads
	always @(posedge ref_clk) begin
		if (mem_wr === 1'b1) begin
			wr_addr.push_back(mem_addr);
			wr_data.push_back(mem_wdata);
		end
		branches += int'(branch === 1'b1);
		delays += int'(delay_rd === 1'b1 && delay_rd_addr === 16'h8000);
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Reset with a strap level, then free the strobe
	task automatic boot(input logic lvl);
		rst_n <= 1'b0;
		boot_host_i.strap(lvl);
		repeat (16) @(posedge ref_clk);
		wr_addr.delete();
		wr_data.delete();
		branches = 0;
		delays = 0;
		rst_n <= 1'b1;
		repeat (30) @(posedge ref_clk);
		check({15'h0, other_mode}, 16'h0000);
		repeat (`STRAP_BASE_CYCLES) @(posedge ref_clk);
		boot_host_i.strap(1'b1);
		repeat (3) @(posedge ref_clk);
		check(16'(delays), 16'h0001);
	endtask
	// One word; a lost handshake ends the run
	task automatic xfer(input logic [15:0] w, input logic ack);
		logic ok;
		boot_host_i.send(w, ack, ok);
		check({15'h0, ok}, 16'h0001);
		if (!ok)
			end_of_test();
	endtask
	task automatic wait_branch();
		int n;
		n = 0;
		while (branches == 0 && n < 50) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (3) @(posedge ref_clk);
		check(16'(branches), 16'h0001);
		check(branch_addr, 16'hFA00);
	endtask
	task automatic t_other();
		boot(1'b1);
		check({15'h0, other_mode}, 16'h0001);
		check(16'(wr_addr.size() + branches), 16'h0000);
	endtask
	task automatic t_narrow();
		boot(1'b0);
		xfer(16'hA508, 1'b1);
		xfer(16'h5B55, 1'b1);
		xfer(16'hC302, 1'b1);
		xfer(16'h7734, 1'b1);
		xfer(16'h6612, 1'b1);
		xfer(16'h00CD, 1'b1);
		xfer(16'h00AB, 1'b1);
		xfer(16'h1101, 1'b1);
		xfer(16'h22BE, 1'b1);
		check(port_out_data, 16'h00FF);
		xfer(16'hDEAD, 1'b0);
		wait_branch();
		check(16'(wr_addr.size()), 16'h0002);
		check(wr_addr[0], 16'h0200);
		check(wr_data[0], 16'h1234);
		check(wr_data[1], 16'hABCD);
		check({10'h0, interrupt_mask}, 16'h0015);
		check({12'h0, blocks}, 16'h0003);
	endtask
	task automatic t_wide();
		boot(1'b0);
		xfer(16'h001E, 1'b1);
		xfer(16'h00AA, 1'b1);
		xfer(16'h0001, 1'b1);
		for (int i = 0; i <= 16'h600; i++)
			xfer(16'(i), 1'b1);
		xfer(16'h0000, 1'b0);
		check(port_out_data, 16'h0000);
		check({15'h0, port_out_valid}, 16'h0001);
		xfer(16'h0000, 1'b0);
		wait_branch();
		check(wr_addr[16'h5FF], 16'h07FF);
		check(wr_addr[16'h600], 16'h0800);
		check(wr_data[16'h600], 16'h0600);
		check({10'h0, interrupt_mask}, 16'h002A);
		check({12'h0, blocks}, 16'h000B);
	endtask
	task automatic t_noload();
		boot(1'b0);
		xfer(16'h0010, 1'b0);
		wait_branch();
		check(16'(wr_addr.size()), 16'h0000);
	endtask
	initial begin
		rst_n = 1'b0;
		bad_count = 0;
		checked = 0;
		t_other();
		t_narrow();
		t_wide();
		t_noload();
		end_of_test();
	end
endmodule // parallel_boot_download_bench

`default_nettype wire
